// ### dac_event_interrupt_unit_tb_top.sv
// Purpose: Self-checking bench for the event interrupt unit.
// Assumes: Reads are checked by a monitor that pops expected bytes from a queue.
// Notes: Route register is random, so either pin may be exercised per event.
`timescale 1ns/10ps
module dac_event_interrupt_unit_tb_top;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic cs_n, sclk, sdio, sdo, oe, irq_pin_first_n, irq_pin_second_n;
    deiu_pkg::deiu_events_a_type ev_a = '0;
    deiu_pkg::deiu_events_b_type ev_b = '0;
    deiu_pkg::deiu_frame_cfg_type cfg;
    logic [2:0] wr_ptr = 3'h3;
    logic [2:0] rd_ptr = 3'h0;
    logic [31:0] seed = 32'he0ac_96fb;
    logic [7:0] exp_q[$];
    logic [7:0] sh, r, v;
    logic [2:0] wt[5] = '{3'h3, 3'h6, 3'h1, 3'h3, 3'h6};
    logic [7:0] fe[5] = '{8'h05, 8'h01, 8'h01, 8'h03, 8'h01};
    int errors = 0, checked = 0, cycles = 0, nb = 0, b;
    deiu_top #(.PTR_W(3)) uut (.clk_i(clk_i), .rstn_i(rstn_i), .spi_cs_n_i(cs_n),
        .spi_sclk_i(sclk), .spi_sdio_i(sdio), .spi_sdio_o(sdo), .spi_sdio_oe_o(oe),
        .events_a_i(ev_a), .events_b_i(ev_b), .fifo_wr_ptr_i(wr_ptr),
        .fifo_rd_ptr_i(rd_ptr), .irq_pin_first_n_o(irq_pin_first_n), .irq_pin_second_n_o(irq_pin_second_n),
        .frame_cfg_o(cfg));
    deiu_host_model #(.HALF(10)) host (.clk_i(clk_i), .sdio_o_i(sdo), .sdio_oe_i(oe),
        .cs_n_o(cs_n), .sclk_o(sclk), .sdio_wire_o(sdio));
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.frame(1'b1, a, 8'h00);
    endtask
    task automatic pins(input logic e1, input logic e2);
        chk({6'h00, irq_pin_first_n, irq_pin_second_n}, {6'h00, e1, e2}, "irq pins");
    endtask
    // Read monitor: device bits sampled on rising sclk while it drives
    always @(posedge sclk) begin
        if (oe === 1'b1) begin
            sh = {sh[6:0], sdo};
            nb++;
            if (nb == 8) begin
                nb = 0;
                chk(sh, exp_q.pop_front(), "read byte");
            end
        end
    end
    // Hang guard, well above the expected run length
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            $display("CHECK FAILED at %0t: timeout", $time);
            close_out();
        end
    end
    initial begin
        tick(3);
        rstn_i = 1'b1;
        tick(4);
        for (int a = 3; a <= 10; a++) rd(7'(a), 8'h00);
        pins(1'b1, 1'b1);
        $display("test reset_values done");
        for (int a = 3; a <= 9; a++) begin
            v = 8'($random(seed));
            host.frame(1'b0, 7'(a), v);
            r = (a == 4 || a == 8) ? deiu_pkg::DEIU_MASK_B : deiu_pkg::DEIU_MASK_A;
            rd(7'(a), (a == 5 || a == 6) ? 8'h0 : v & (a == 9 ? 8'h33 : r));
        end
        for (int f = 0; f < 4; f++) begin
            v = {2'b00, f == 1, f == 2, 2'b00, 2'(f)};
            host.frame(1'b0, 7'h09, v);
            chk({4'h0, cfg}, {4'h0, v[5], v[4], v[1:0]}, "frame cfg");
        end
        $display("test register_access done");
        // Disabled events still flag but never reach a pin
        host.frame(1'b0, 7'h03, 8'h00);
        host.frame(1'b0, 7'h04, 8'h00);
        ev_a = '1;
        ev_b = '1;
        tick(1);
        ev_a = '0;
        ev_b = '0;
        tick(3);
        pins(1'b1, 1'b1);
        rd(7'h05, 8'h7F);
        rd(7'h06, 8'hF0);
        r = 8'($random(seed));
        host.frame(1'b0, 7'h07, r & 8'h7F);
        host.frame(1'b0, 7'h08, r & 8'hF0);
        host.frame(1'b0, 7'h03, 8'h7F);
        host.frame(1'b0, 7'h04, 8'hF0);
        for (int i = 0; i < 11; i++) begin
            if (i < 7) ev_a = deiu_pkg::deiu_events_a_type'(7'h01 << i);
            else ev_b = deiu_pkg::deiu_events_b_type'(4'h1 << (i - 7));
            tick(1);
            ev_a = '0;
            ev_b = '0;
            tick(3);
            b = (i < 7) ? i : i - 3;
            pins(r[b], !r[b]);
            if (i < 7) rd(7'h05, 8'h01 << b);
            else rd(7'h06, 8'h01 << b);
            pins(1'b1, 1'b1);
        end
        $display("test event_routing done");
        host.frame(1'b0, 7'h08, 8'h00);
        host.frame(1'b0, 7'h04, 8'h07);
        for (int i = 0; i < 5; i++) begin
            rd_ptr = 3'h3;
            wr_ptr = wt[i];
            tick(3);
            pins(1'b0, 1'b1);
            rd(7'h06, fe[i]);
        end
        pins(1'b1, 1'b1);
        $display("test fifo_events done");
        close_out();
    end
endmodule

// ### deiu_asserts.sv
// Purpose: Port-level checker for the event interrupt unit.
// Assumes: Host keeps cs_n low a half sclk period after the last falling sclk.
// Notes: Pins may only move on an event two clocks earlier or during a frame.
`timescale 1ns/10ps
module deiu_asserts #(
    parameter int PTR_W = 3
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sclk_i,
    input wire logic spi_sdio_o,
    input wire logic spi_sdio_oe_o,
    input wire deiu_pkg::deiu_events_a_type events_a_i,
    input wire deiu_pkg::deiu_events_b_type events_b_i,
    input wire logic [PTR_W-1:0] fifo_wr_ptr_i,
    input wire logic [PTR_W-1:0] fifo_rd_ptr_i,
    input wire logic irq_pin_first_n_o,
    input wire logic irq_pin_second_n_o,
    input wire deiu_pkg::deiu_frame_cfg_type frame_cfg_o
);
    logic [PTR_W-1:0] wr_q;
    logic [PTR_W-1:0] rd_q;
    logic [PTR_W-1:0] occ;
    logic cause;
    // Anything that may set a flag; FIFO warning is a level, so it counts too
    assign occ = fifo_wr_ptr_i - fifo_rd_ptr_i;
    assign cause = (|events_a_i) || (|events_b_i) || (wr_q != fifo_wr_ptr_i)
        || (rd_q != fifo_rd_ptr_i) || (occ <= 1) || (occ >= 6);
    // Previous pointers, to see them move
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= fifo_wr_ptr_i;
            rd_q <= fifo_rd_ptr_i;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    property p_rst_quiet;
        $rose(rstn_i) |-> (irq_pin_first_n_o && irq_pin_second_n_o) [*8];
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("irq active after reset");
    property p_first_hold;
        $rose(irq_pin_first_n_o) |-> !spi_cs_n_i;
    endproperty
    a_first_hold: assert property (p_first_hold) else $error("first pin released");
    property p_second_hold;
        $rose(irq_pin_second_n_o) |-> !spi_cs_n_i;
    endproperty
    a_second_hold: assert property (p_second_hold) else $error("second pin released");
    property p_first_cause;
        $fell(irq_pin_first_n_o) |-> $past(cause, 2) || !spi_cs_n_i;
    endproperty
    a_first_cause: assert property (p_first_cause) else $error("first pin no cause");
    property p_second_cause;
        $fell(irq_pin_second_n_o) |-> $past(cause, 2) || !spi_cs_n_i;
    endproperty
    a_second_cause: assert property (p_second_cause) else $error("second pin no cause");
    property p_cfg_write;
        $changed(frame_cfg_o) |-> !spi_cs_n_i;
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("cfg moved outside frame");
    property p_oe_start;
        $rose(spi_sdio_oe_o) |-> !spi_cs_n_i && !spi_sclk_i;
    endproperty
    a_oe_start: assert property (p_oe_start) else $error("read drive started badly");
    property p_sdo_stable;
        spi_sdio_oe_o && spi_sclk_i && $past(spi_sclk_i, 6) |-> $stable(spi_sdio_o);
    endproperty
    a_sdo_stable: assert property (p_sdo_stable) else $error("read data moved");
    c_first_low: cover property ($fell(irq_pin_first_n_o));
    c_second_low: cover property ($fell(irq_pin_second_n_o));
    c_read: cover property ($rose(spi_sdio_oe_o));
endmodule
bind deiu_top deiu_asserts #(.PTR_W(PTR_W)) u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
    .spi_cs_n_i(spi_cs_n_i), .spi_sclk_i(spi_sclk_i), .spi_sdio_o(spi_sdio_o),
    .spi_sdio_oe_o(spi_sdio_oe_o), .events_a_i(events_a_i), .events_b_i(events_b_i),
    .fifo_wr_ptr_i(fifo_wr_ptr_i), .fifo_rd_ptr_i(fifo_rd_ptr_i),
    .irq_pin_first_n_o(irq_pin_first_n_o), .irq_pin_second_n_o(irq_pin_second_n_o),
    .frame_cfg_o(frame_cfg_o));

// ### deiu_flag_bank.sv
// Purpose: Bank of sticky event flags with a clear strobe.
// Assumes: Set inputs come from logic on clk_i.
// Notes: A set in the clear cycle keeps the flag, so no event is lost.
`timescale 1ns/10ps
module deiu_flag_bank #(
    parameter int W = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [W-1:0] set_i,
    input wire logic clr_i,
    output logic [W-1:0] flags_o
);

    typedef struct packed {
        logic [W-1:0] flags;
    } deiu_flag_state_type;

    deiu_flag_state_type st_q;
    deiu_flag_state_type st_d;

    // Set wins over clear; a held source re-sets its flag every cycle
    always_comb begin
        st_d = st_q;
        if (clr_i) begin
            st_d.flags = set_i;
        end else begin
            st_d.flags = st_q.flags | set_i;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q <= RST_VAL;
        end else begin
            st_q <= st_d;
        end
    end

    assign flags_o = st_q.flags;

endmodule

// ### deiu_host_model.sv
// Purpose: Host on the three-wire serial port.
// Assumes: Half sclk period of HALF clocks keeps the pin filter happy.
// Notes: sclk stands low between frames; a released host shows the inverse level.
`timescale 1ns/10ps
module deiu_host_model #(
    parameter int HALF = 10
) (
    input wire logic clk_i,
    input wire logic sdio_o_i,
    input wire logic sdio_oe_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic sdio_wire_o
);
    logic drv = 1'b0;
    logic own = 1'b1;
    // Shared data wire: device wins while it drives
    assign sdio_wire_o = sdio_oe_i ? sdio_o_i : (own ? drv : ~drv);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // One frame, MSB first; host changes data on falling sclk only
    task automatic frame(input logic rw, input logic [6:0] addr, input logic [7:0] wd);
        logic [15:0] bits;
        bits = {rw, addr, wd};
        tick(1);
        cs_n_o = 1'b0;
        tick(HALF);
        for (int i = 15; i >= 0; i--) begin
            sclk_o = 1'b0;
            own = !(rw && i < 8);
            if (own) drv = bits[i];
            tick(HALF);
            sclk_o = 1'b1;
            tick(HALF);
        end
        sclk_o = 1'b0;
        own = 1'b1;
        tick(HALF);
        cs_n_o = 1'b1;
        tick(6);
    endtask
endmodule

// ### deiu_pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Inputs are asynchronous to clk_i.
// Notes: Output moves only when the second and third stages agree.
`timescale 1ns/10ps
module deiu_pin_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] level_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] level;
    } deiu_sync_state_type;

    deiu_sync_state_type st_q;
    deiu_sync_state_type st_d;

    // First stage feeds only the second; filter looks at stages two and three
    always_comb begin
        st_d = st_q;
        st_d.s1 = pin_i;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < W; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.level[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign level_o = st_q.level;

endmodule

// ### deiu_pkg.sv
// Purpose: Shared constants and types for the converter event interrupt unit.
// Assumes: Eight-bit registers on a seven-bit address serial control port.
// Notes: Offsets, reset values, field positions and counts live here only.
package deiu_pkg;

    // Register offsets on the serial control port
    localparam logic [6:0] DEIU_OFF_EN_A = 7'h03;
    localparam logic [6:0] DEIU_OFF_EN_B = 7'h04;
    localparam logic [6:0] DEIU_OFF_FLAGS_A = 7'h05;
    localparam logic [6:0] DEIU_OFF_FLAGS_B = 7'h06;
    localparam logic [6:0] DEIU_OFF_ROUTE_A = 7'h07;
    localparam logic [6:0] DEIU_OFF_ROUTE_B = 7'h08;
    localparam logic [6:0] DEIU_OFF_FRAME_CFG = 7'h09;

    // Values after reset
    localparam logic [7:0] DEIU_RST_EN = 8'h00;
    localparam logic [7:0] DEIU_RST_FLAGS = 8'h00;
    localparam logic [7:0] DEIU_RST_ROUTE = 8'h00;
    localparam logic [7:0] DEIU_RST_FRAME_CFG = 8'h00;

    // Implemented bits; the rest read as zero
    localparam logic [7:0] DEIU_MASK_A = 8'h7F;
    localparam logic [7:0] DEIU_MASK_B = 8'hF7;

    // Frame configuration field positions
    localparam int DEIU_POS_PAR_USE = 5;
    localparam int DEIU_POS_FRM_USE = 4;
    localparam int DEIU_POS_FN_LO = 0;

    // FIFO warning thresholds in slots
    localparam int DEIU_FIFO_WARN_LOW = 1;
    localparam int DEIU_FIFO_WARN_HIGH = 6;

    // Serial frame: one read/write bit, seven address bits, eight data bits
    localparam logic [4:0] DEIU_LAST_INSTR_BIT = 5'h07;
    localparam logic [4:0] DEIU_LAST_DATA_BIT = 5'h0F;
    localparam logic [4:0] DEIU_BIT_CNT_END = 5'h10;
    localparam int DEIU_POS_RW = 7;

    // Pin synchroniser reset image, ordered {cs_n, sclk, sdio}
    localparam logic [2:0] DEIU_PIN_RST = 3'h4;

    typedef enum logic [1:0] {
        DEIU_FN_NONE = 2'b00,
        DEIU_FN_PARITY = 2'b01,
        DEIU_FN_FRAME = 2'b10,
        DEIU_FN_RSVD = 2'b11
    } deiu_frame_fn_type;

    typedef enum logic [1:0] {
        DEIU_PH_IDLE = 2'b00,
        DEIU_PH_INSTR = 2'b01,
        DEIU_PH_DATA = 2'b10,
        DEIU_PH_DONE = 2'b11
    } deiu_phase_type;

    // First group of event sources, one level per event
    typedef struct packed {
        logic sync_lost;
        logic sync_locked;
        logic sync_done;
        logic clk_mult_lost;
        logic clk_mult_locked;
        logic over_threshold;
        logic output_muted;
    } deiu_events_a_type;

    // Second group of event sources; FIFO events are derived internally
    typedef struct packed {
        logic parity_fail;
        logic sample_error;
        logic loop_warning;
        logic loop_locked;
    } deiu_events_b_type;

    typedef struct packed {
        logic parity_in_use;
        logic frame_in_use;
        deiu_frame_fn_type frame_pin_function;
    } deiu_frame_cfg_type;

endpackage

// ### deiu_top.sv
// Purpose: Event interrupt unit of a converter, reached over a three-wire serial port.
// Assumes: Event sources and FIFO pointers run on clk_i; serial pins are asynchronous.
// Notes: Serial clock must stay well below clk_i because pins pass a three-stage filter.
//
// Behaviour
// - First enable register gates sync, multiplier lock, power and mute interrupts.
// - Second enable register gates parity, sample error, loop and FIFO interrupts.
// - Both enable registers reset to zero, all interrupts disabled.
// - Sync-lost flag, bit 6 of first flags, sets when sync is lost.
// - Sync-locked flag bit 5 and sync-done flag bit 4 set on their events.
// - Multiplier lock-lost bit 3 and locked bit 2 set on their events.
// - Over-threshold flag bit 1 sets when input power exceeds threshold.
// - Output-muted flag bit 0 sets while output is forced to midscale.
// - Parity-failure flag, bit 7 of second flags, sets on parity error.
// - Sample-error flag bit 6 sets when pattern comparison fails.
// - Loop-warning bit 5 and loop-locked bit 4 set on loop events.
// - FIFO underflow flag bit 2 sets when read pointer catches write pointer.
// - FIFO overflow flag bit 1 sets when write pointer catches read pointer.
// - FIFO warning flag bit 0 sets when occupancy is at most 1 or at least 6.
// - Both flag registers are read-only and reset to zero.
// - Routing bit zero sends event to first pin, one to second pin.
// - Both routing registers reset to zero, all events on first pin.
// - Two-bit frame pin field: none, parity input, frame input, reserved.
`timescale 1ns/10ps
module deiu_top #(
    parameter int PTR_W = 3
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sclk_i,
    input wire logic spi_sdio_i,
    output logic spi_sdio_o,
    output logic spi_sdio_oe_o,
    input wire deiu_pkg::deiu_events_a_type events_a_i,
    input wire deiu_pkg::deiu_events_b_type events_b_i,
    input wire logic [PTR_W-1:0] fifo_wr_ptr_i,
    input wire logic [PTR_W-1:0] fifo_rd_ptr_i,
    output logic irq_pin_first_n_o,
    output logic irq_pin_second_n_o,
    output deiu_pkg::deiu_frame_cfg_type frame_cfg_o
);

    typedef struct packed {
        logic [7:0] en_a;
        logic [7:0] en_b;
        logic [7:0] route_a;
        logic [7:0] route_b;
        deiu_pkg::deiu_frame_cfg_type frame_cfg;
        logic [PTR_W-1:0] wr_ptr_prev;
        logic [PTR_W-1:0] rd_ptr_prev;
        deiu_pkg::deiu_phase_type phase;
        logic [4:0] bit_cnt;
        logic [7:0] instr;
        logic [7:0] rx;
        logic [7:0] tx;
        logic sclk_prev;
        logic sdo;
        logic sdo_oe;
        logic clr_a;
        logic clr_b;
        logic irq_pin_first_n;
        logic irq_pin_second_n;
    } deiu_top_state_type;

    deiu_top_state_type st_q;
    deiu_top_state_type st_d;

    logic [2:0] pins_s;
    logic cs_n_s;
    logic sclk_s;
    logic sdi_s;
    logic [7:0] flags_a;
    logic [7:0] flags_b;
    logic [7:0] set_a;
    logic [7:0] set_b;
    logic fifo_under;
    logic fifo_over;
    logic fifo_warn;
    logic [PTR_W-1:0] fifo_occ;

    // Read view of the register file; unmapped and reserved bits read as zero
    function automatic logic [7:0] read_mux(
        input logic [6:0] addr,
        input deiu_top_state_type s,
        input logic [7:0] fa,
        input logic [7:0] fb
    );
        logic [7:0] v;
        v = 8'h00;
        if (addr == deiu_pkg::DEIU_OFF_EN_A) begin
            v = s.en_a;
        end else if (addr == deiu_pkg::DEIU_OFF_EN_B) begin
            v = s.en_b;
        end else if (addr == deiu_pkg::DEIU_OFF_FLAGS_A) begin
            v = fa;
        end else if (addr == deiu_pkg::DEIU_OFF_FLAGS_B) begin
            v = fb;
        end else if (addr == deiu_pkg::DEIU_OFF_ROUTE_A) begin
            v = s.route_a;
        end else if (addr == deiu_pkg::DEIU_OFF_ROUTE_B) begin
            v = s.route_b;
        end else if (addr == deiu_pkg::DEIU_OFF_FRAME_CFG) begin
            v[deiu_pkg::DEIU_POS_PAR_USE] = s.frame_cfg.parity_in_use;
            v[deiu_pkg::DEIU_POS_FRM_USE] = s.frame_cfg.frame_in_use;
            v[deiu_pkg::DEIU_POS_FN_LO +: 2] = s.frame_cfg.frame_pin_function;
        end
        return v;
    endfunction

    // One pin is asserted when an enabled, flagged event is routed to it
    function automatic logic pin_hit(
        input logic [7:0] flags,
        input logic [7:0] en,
        input logic [7:0] route,
        input logic [7:0] mask,
        input logic second
    );
        logic [7:0] sel;
        sel = second ? route : ~route;
        return |(flags & en & sel & mask);
    endfunction

    // All three serial pins share one filter so their relative timing is kept
    deiu_pin_sync #(
        .W(3),
        .RST_VAL(deiu_pkg::DEIU_PIN_RST)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .pin_i({spi_cs_n_i, spi_sclk_i, spi_sdio_i}),
        .level_o(pins_s)
    );

    assign cs_n_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign sdi_s = pins_s[0];

    // FIFO events from pointer movement and occupancy; a pointer that moves onto the other one collides
    assign fifo_occ = fifo_wr_ptr_i - fifo_rd_ptr_i;
    assign fifo_under = (fifo_rd_ptr_i != st_q.rd_ptr_prev)
        && (fifo_rd_ptr_i == fifo_wr_ptr_i);
    assign fifo_over = (fifo_wr_ptr_i != st_q.wr_ptr_prev)
        && (fifo_wr_ptr_i == fifo_rd_ptr_i);
    assign fifo_warn = (fifo_occ <= PTR_W'(deiu_pkg::DEIU_FIFO_WARN_LOW))
        || (fifo_occ >= PTR_W'(deiu_pkg::DEIU_FIFO_WARN_HIGH));

    // Event sources mapped onto flag positions
    assign set_a = {1'b0, events_a_i.sync_lost,
        events_a_i.sync_locked, events_a_i.sync_done,
        events_a_i.clk_mult_lost, events_a_i.clk_mult_locked,
        events_a_i.over_threshold,
        events_a_i.output_muted};
    assign set_b = {events_b_i.parity_fail,
        events_b_i.sample_error,
        events_b_i.loop_warning, events_b_i.loop_locked,
        1'b0, fifo_under, fifo_over, fifo_warn};

    // Flag registers have no write path from the serial port
    deiu_flag_bank #(
        .W(8),
        .RST_VAL(deiu_pkg::DEIU_RST_FLAGS)
    ) u_flags_a (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .set_i(set_a),
        .clr_i(st_q.clr_a),
        .flags_o(flags_a)
    );

    deiu_flag_bank #(
        .W(8),
        .RST_VAL(deiu_pkg::DEIU_RST_FLAGS)
    ) u_flags_b (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .set_i(set_b),
        .clr_i(st_q.clr_b),
        .flags_o(flags_b)
    );

    // Serial slave, register writes and interrupt pins
    always_comb begin
        logic rise;
        logic fall;
        logic is_read;
        logic [6:0] addr;
        rise = 1'b0;
        fall = 1'b0;
        is_read = 1'b0;
        addr = 7'h00;
        st_d = st_q;
        rise = sclk_s && !st_q.sclk_prev;
        fall = !sclk_s && st_q.sclk_prev;
        is_read = st_q.instr[deiu_pkg::DEIU_POS_RW];
        addr = st_q.instr[6:0];
        st_d.sclk_prev = sclk_s;
        st_d.wr_ptr_prev = fifo_wr_ptr_i;
        st_d.rd_ptr_prev = fifo_rd_ptr_i;
        st_d.clr_a = 1'b0;
        st_d.clr_b = 1'b0;
        if (cs_n_s) begin
            // Deselect aborts any frame and releases the data pin
            st_d.phase = deiu_pkg::DEIU_PH_IDLE;
            st_d.bit_cnt = 5'h00;
            st_d.sdo_oe = 1'b0;
            st_d.sdo = 1'b0;
        end else begin
            case (st_q.phase)
                deiu_pkg::DEIU_PH_IDLE: begin
                    st_d.phase = deiu_pkg::DEIU_PH_INSTR;
                    st_d.bit_cnt = 5'h00;
                    if (rise) begin
                        st_d.instr = {st_q.instr[6:0], sdi_s};
                        st_d.bit_cnt = 5'h01;
                    end
                end
                deiu_pkg::DEIU_PH_INSTR: begin
                    if (rise) begin
                        st_d.instr = {st_q.instr[6:0], sdi_s};
                        st_d.bit_cnt = st_q.bit_cnt + 5'h01;
                        if (st_q.bit_cnt == deiu_pkg::DEIU_LAST_INSTR_BIT) begin
                            st_d.phase = deiu_pkg::DEIU_PH_DATA;
                        end
                    end
                end
                deiu_pkg::DEIU_PH_DATA: begin
                    if (st_q.bit_cnt == 5'h08 && is_read && !st_q.sdo_oe && !fall
                        && st_q.tx == 8'h00 && st_q.rx == 8'h00) begin
                        st_d.tx = read_mux(addr, st_q, flags_a, flags_b);
                        // Reading a flag register clears flags whose sources are gone
                        st_d.clr_a = (addr == deiu_pkg::DEIU_OFF_FLAGS_A);
                        st_d.clr_b = (addr == deiu_pkg::DEIU_OFF_FLAGS_B);
                        st_d.rx = 8'h01;
                    end
                    if (fall && is_read) begin
                        // Read data leaves on falling edges, host samples on rising
                        st_d.sdo = st_q.tx[7];
                        st_d.tx = {st_q.tx[6:0], 1'b0};
                        st_d.sdo_oe = 1'b1;
                    end
                    if (rise) begin
                        st_d.bit_cnt = st_q.bit_cnt + 5'h01;
                        if (!is_read) begin
                            st_d.rx = {st_q.rx[6:0], sdi_s};
                        end
                        if (st_q.bit_cnt == deiu_pkg::DEIU_LAST_DATA_BIT) begin
                            st_d.phase = deiu_pkg::DEIU_PH_DONE;
                        end
                    end
                end
                deiu_pkg::DEIU_PH_DONE: begin
                    st_d.bit_cnt = deiu_pkg::DEIU_BIT_CNT_END;
                    if (!is_read) begin
                        // Register write on the sixteenth bit; flag and unmapped addresses ignore it
                        if (addr == deiu_pkg::DEIU_OFF_EN_A) begin
                            st_d.en_a = st_q.rx & deiu_pkg::DEIU_MASK_A;
                        end else if (addr == deiu_pkg::DEIU_OFF_EN_B) begin
                            st_d.en_b = st_q.rx & deiu_pkg::DEIU_MASK_B;
                        end else if (addr == deiu_pkg::DEIU_OFF_ROUTE_A) begin
                            st_d.route_a = st_q.rx & deiu_pkg::DEIU_MASK_A;
                        end else if (addr == deiu_pkg::DEIU_OFF_ROUTE_B) begin
                            st_d.route_b = st_q.rx & deiu_pkg::DEIU_MASK_B;
                        end else if (addr == deiu_pkg::DEIU_OFF_FRAME_CFG) begin
                            st_d.frame_cfg.parity_in_use = st_q.rx[deiu_pkg::DEIU_POS_PAR_USE];
                            st_d.frame_cfg.frame_in_use = st_q.rx[deiu_pkg::DEIU_POS_FRM_USE];
                            st_d.frame_cfg.frame_pin_function =
                                deiu_pkg::deiu_frame_fn_type'(
                                st_q.rx[deiu_pkg::DEIU_POS_FN_LO +: 2]);
                        end
                        st_d.instr[deiu_pkg::DEIU_POS_RW] = 1'b1;
                        st_d.instr[6:0] = 7'h7F;
                    end
                    // Extra clocks after the frame are ignored until deselect
                    if (fall && is_read) begin
                        st_d.sdo_oe = 1'b0;
                    end
                end
                default: begin
                    st_d.phase = deiu_pkg::DEIU_PH_IDLE;
                end
            endcase
            if (st_q.phase == deiu_pkg::DEIU_PH_INSTR && rise
                && st_q.bit_cnt == deiu_pkg::DEIU_LAST_INSTR_BIT) begin
                st_d.tx = 8'h00;
                st_d.rx = 8'h00;
            end
        end
        // Pins are registered; one cycle after a flag or enable change
        st_d.irq_pin_first_n = !(pin_hit(flags_a, st_q.en_a, st_q.route_a, deiu_pkg::DEIU_MASK_A, 1'b0)
            || pin_hit(flags_b, st_q.en_b, st_q.route_b, deiu_pkg::DEIU_MASK_B, 1'b0));
        st_d.irq_pin_second_n = !(pin_hit(flags_a, st_q.en_a, st_q.route_a, deiu_pkg::DEIU_MASK_A, 1'b1)
            || pin_hit(flags_b, st_q.en_b, st_q.route_b, deiu_pkg::DEIU_MASK_B, 1'b1));
    end

    // Control state resets to documented defaults; pins idle inactive
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q <= '0;
            st_q.en_a <= deiu_pkg::DEIU_RST_EN;
            st_q.en_b <= deiu_pkg::DEIU_RST_EN;
            st_q.route_a <= deiu_pkg::DEIU_RST_ROUTE;
            st_q.route_b <= deiu_pkg::DEIU_RST_ROUTE;
            st_q.frame_cfg <= {deiu_pkg::DEIU_RST_FRAME_CFG[5:4],
                deiu_pkg::DEIU_RST_FRAME_CFG[1:0]};
            st_q.phase <= deiu_pkg::DEIU_PH_IDLE;
            st_q.irq_pin_first_n <= 1'b1;
            st_q.irq_pin_second_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign spi_sdio_o = st_q.sdo;
    assign spi_sdio_oe_o = st_q.sdo_oe;
    assign irq_pin_first_n_o = st_q.irq_pin_first_n;
    assign irq_pin_second_n_o = st_q.irq_pin_second_n;
    assign frame_cfg_o = st_q.frame_cfg;

endmodule
